// File: plc_pkg.sv
// Package for the port LED and output control block.
// Assumes a 10 MHz system clock and synchronous active-low reset.
package plc_pkg;
   localparam int PORTS = 4;
   localparam int CLK_HZ = 10000000;
   localparam int BLINK_STEP_US = 2500;
   localparam int STEP_CYCLES = BLINK_STEP_US * (CLK_HZ / 1000000);
   localparam logic [7:0] INTENSITY_RST = 8'h00;
   localparam logic [7:0] BLINK_TIME_RST = 8'h01;
   localparam logic OUT_A_RST = 1'b1;
   localparam logic OUT_B_RST = 1'b0;
   localparam logic PROTO_I2C = 1'b0;
   localparam logic PROTO_SPI = 1'b1;

   typedef enum logic [3:0] {
      PLC_LED_OFF = 4'h1,
      PLC_LED_ON = 4'h2,
      PLC_LED_PWM = 4'h4,
      PLC_LED_BLINK = 4'h8
   } plc_led_mode_t;

   typedef struct packed {
      plc_led_mode_t mode;
      logic [7:0] intensity;
      logic [7:0] on_time;
      logic [7:0] off_time;
   } plc_led_cfg_t;

   typedef enum logic [2:0] {
      PLC_OW_PORT = 3'h1,
      PLC_OW_DEVICE = 3'h2,
      PLC_OW_BCAST = 3'h4
   } plc_out_scope_t;

   typedef struct packed {
      logic en_a;
      logic en_b;
      logic val_a;
      logic val_b;
   } plc_out_cfg_t;
endpackage

// File: plc_led_chan.sv
// One LED channel: steady, dimmed or blinking drive, active low.
// Assumes a shared PWM phase and blink phase from the parent.
`timescale 1ns/1ps
module plc_led_chan (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire plc_pkg::plc_led_cfg_t i_cfg,
   input wire logic [7:0] i_pwm_phase,
   input wire logic i_blink_on,
   output logic o_led_n
);
   logic lit_d;
   logic lit_q;
   wire pwm_lit = (i_pwm_phase < i_cfg.intensity); // intensity 0 never lights
   always_comb begin
      case (i_cfg.mode)
         plc_pkg::PLC_LED_ON: lit_d = 1'b1;
         plc_pkg::PLC_LED_PWM: lit_d = pwm_lit;
         plc_pkg::PLC_LED_BLINK: lit_d = pwm_lit & i_blink_on;
         default: lit_d = 1'b0;
      endcase
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) lit_q <= 1'b0;
      else lit_q <= lit_d;
   end
   assign o_led_n = ~lit_q;
   a_dark_at_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_cfg.mode != plc_pkg::PLC_LED_ON && i_cfg.intensity == 8'h00)
      |=> (o_led_n == 1'b1))
      else $error("LED lit with zero intensity");
   a_off_dark: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_cfg.mode == plc_pkg::PLC_LED_OFF |=> o_led_n == 1'b1)
      else $error("LED lit in off mode");
   a_on_lit_low: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_cfg.mode == plc_pkg::PLC_LED_ON |=> o_led_n == 1'b0)
      else $error("LED not driven low in on mode");
endmodule // plc_led_chan

// File: plc_top.sv
// Four-port LED driver with blink timebase sharing and control outputs.
// Assumes synchronous inputs; the host protocol logic sits outside.
`timescale 1ns/1ps
// Behaviour
// - Strap level picks I2C or SPI host protocol mode.
// - Two LED drive lines per port, four ports.
// - LED lines are active low: low lights the LED.
// - LED lines tri-stated while in reset.
// - After reset LED lines driven high until configured.
// - Each LED is on, off, dimmed or blinking.
// - Blink on and off phases timed from separate settings.
// - 256 intensity settings; 0 dark, 255 brightest.
// - Intensity is not reset here; 0 keeps dimmed and blinking LEDs dark, on mode ignores it.
// - All ports blink from one common timebase.
// - SPI mode: drive or receive timebase on the sync pin.
// - I2C mode: chain head drives out, others relay in to out.
// - Two control outputs per port; update per port, device, or broadcast.
// - Control output enables reset to disabled, lines tri-stated.
// - First control line resets to one, second to zero.
module plc_top #(
   parameter int PORTS = plc_pkg::PORTS,
   parameter int STEP_CYCLES = plc_pkg::STEP_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_proto_sel,
   input wire logic i_tb_master,
   input wire plc_pkg::plc_led_cfg_t [2*PORTS-1:0] i_led_cfg,
   input wire logic i_blink_sync_pin_i,
   input wire logic i_blink_chain_in,
   input wire logic i_out_we,
   input wire plc_pkg::plc_out_scope_t i_out_scope,
   input wire logic [1:0] i_out_port,
   input wire plc_pkg::plc_out_cfg_t i_out_wdata,
   output logic o_proto_spi,
   output logic [PORTS-1:0] o_led_c_n,
   output logic [PORTS-1:0] o_led_d_n,
   output logic o_led_oe,
   output logic o_blink_sync_pin_o,
   output logic o_blink_sync_pin_oe,
   output logic o_blink_chain_out,
   output logic [PORTS-1:0] o_out_a,
   output logic [PORTS-1:0] o_out_a_oe,
   output logic [PORTS-1:0] o_out_b,
   output logic [PORTS-1:0] o_out_b_oe
);
   logic proto_q;
   logic run_q;
   logic [7:0] pwm_q;
   logic [$clog2(STEP_CYCLES)-1:0] pre_q;
   logic step_tick;
   logic tb_q;
   logic tb_prev_q;
   logic tb_edge;
   logic blink_on_q;
   logic [7:0] phase_cnt_q;
   logic [PORTS-1:0] led_c_raw;
   logic [PORTS-1:0] led_d_raw;
   // Unpacked so each port's flop block owns its own element
   plc_pkg::plc_out_cfg_t out_q [PORTS];

   // Strap sampled each reset cycle; latched value held after release
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) proto_q <= i_proto_sel;
   end
   assign o_proto_spi = proto_q;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) run_q <= 1'b0;
      else run_q <= 1'b1;
   end
   assign o_led_oe = run_q;

   // Internal 2.5 ms timebase tick
   assign step_tick = (pre_q == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1));
   always_ff @(posedge i_clock) begin
      if (!i_rst_n || step_tick) pre_q <= '0;
      else pre_q <= pre_q + 1'b1;
   end

   // Timebase source: own tick when master, else the incoming pin
   wire ext_tb = (proto_q == plc_pkg::PROTO_SPI) ? i_blink_sync_pin_i : i_blink_chain_in;
   wire tb_level = i_tb_master ? tb_q : ext_tb;
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tb_q <= 1'b0;
         tb_prev_q <= 1'b0;
      end else begin
         if (step_tick) tb_q <= ~tb_q;
         tb_prev_q <= tb_level;
      end
   end
   assign tb_edge = tb_level ^ tb_prev_q; // each toggle is one 2.5 ms step
   assign o_blink_sync_pin_o = tb_q;
   assign o_blink_sync_pin_oe = run_q && proto_q == plc_pkg::PROTO_SPI && i_tb_master;
   assign o_blink_chain_out = (proto_q == plc_pkg::PROTO_I2C) ? tb_level : 1'b1;

   // Shared blink phase for all ports; settings from LED 0 of port 0
   wire [7:0] on_t = (i_led_cfg[0].on_time == 8'h00) ? 8'h01 : i_led_cfg[0].on_time;
   wire [7:0] off_t = (i_led_cfg[0].off_time == 8'h00) ? 8'h01 : i_led_cfg[0].off_time;
   wire [7:0] phase_len = blink_on_q ? on_t : off_t;
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         blink_on_q <= 1'b1;
         phase_cnt_q <= 8'h00;
      end else if (tb_edge) begin
         if (phase_cnt_q + 8'h01 >= phase_len) begin
            phase_cnt_q <= 8'h00;
            blink_on_q <= ~blink_on_q;
         end else phase_cnt_q <= phase_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) pwm_q <= 8'h00;
      else pwm_q <= pwm_q + 8'h01;
   end

   genvar g;
   generate
      for (g = 0; g < PORTS; g++) begin : g_port
         plc_led_chan u_c (
            .i_clock(i_clock),
            .i_rst_n(i_rst_n),
            .i_cfg(i_led_cfg[2*g]),
            .i_pwm_phase(pwm_q),
            .i_blink_on(blink_on_q),
            .o_led_n(led_c_raw[g])
         );
         plc_led_chan u_d (
            .i_clock(i_clock),
            .i_rst_n(i_rst_n),
            .i_cfg(i_led_cfg[2*g+1]),
            .i_pwm_phase(pwm_q),
            .i_blink_on(blink_on_q),
            .o_led_n(led_d_raw[g])
         );
         // Device and broadcast scopes both hit every local port
         wire hit = i_out_we && (i_out_scope != plc_pkg::PLC_OW_PORT
            || i_out_port == 2'(g));
         always_ff @(posedge i_clock) begin
            if (!i_rst_n) begin
               out_q[g].en_a <= 1'b0;
               out_q[g].en_b <= 1'b0;
               out_q[g].val_a <= plc_pkg::OUT_A_RST;
               out_q[g].val_b <= plc_pkg::OUT_B_RST;
            end else if (hit) out_q[g] <= i_out_wdata;
         end
         assign o_out_a[g] = out_q[g].val_a;
         assign o_out_b[g] = out_q[g].val_b;
         assign o_out_a_oe[g] = out_q[g].en_a;
         assign o_out_b_oe[g] = out_q[g].en_b;
      end
   endgenerate
   assign o_led_c_n = led_c_raw | {PORTS{~run_q}};
   assign o_led_d_n = led_d_raw | {PORTS{~run_q}};

   a_led_tristate: assert property (@(posedge i_clock)
      !i_rst_n |=> !o_led_oe) else $error("LED enabled in reset");
   // Lines forced high on the release edge, enable follows one edge later
   a_led_high_post: assert property (@(posedge i_clock)
      !i_rst_n ##1 i_rst_n |-> ((&o_led_c_n) && (&o_led_d_n)) ##1 o_led_oe)
      else $error("LED not high after reset");
   a_out_en_reset: assert property (@(posedge i_clock)
      !i_rst_n |=> (o_out_a_oe == '0 && o_out_b_oe == '0))
      else $error("Output enabled after reset");
   a_out_val_reset: assert property (@(posedge i_clock)
      !i_rst_n |=> (&o_out_a) && (o_out_b == '0))
      else $error("Output value reset wrong");
   a_out_bcast: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_out_we && i_out_scope == plc_pkg::PLC_OW_BCAST
      |=> o_out_a_oe == {PORTS{$past(i_out_wdata.en_a)}})
      else $error("Broadcast write missed a port");
   a_sync_drive: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_blink_sync_pin_oe |-> proto_q == plc_pkg::PROTO_SPI && i_tb_master)
      else $error("Sync pin driven wrongly");
   a_sync_toggle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_blink_sync_pin_oe && step_tick |=> o_blink_sync_pin_o != $past(o_blink_sync_pin_o))
      else $error("Sync pin missed a tick");
   a_chain_relay: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      proto_q == plc_pkg::PROTO_I2C && !i_tb_master |-> o_blink_chain_out == i_blink_chain_in)
      else $error("Chain not relayed");
   a_tick_period: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      step_tick |=> !step_tick) else $error("Tick too frequent");
   a_proto_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $stable(i_rst_n) |=> $stable(o_proto_spi)) else $error("Protocol changed");
endmodule // plc_top

// File: plc_port_model.sv
// Port-side model: LEDs and module control inputs on the far side.
// Assumes pull-up on line A and pull-down on line B when released.
`timescale 1ns/1ps
module plc_port_model (
   input wire logic [3:0] i_led_c_n,
   input wire logic [3:0] i_led_d_n,
   input wire logic i_led_oe,
   input wire logic [3:0] i_a,
   input wire logic [3:0] i_a_oe,
   input wire logic [3:0] i_b,
   input wire logic [3:0] i_b_oe,
   output logic [3:0] o_lit_c,
   output logic [3:0] o_lit_d,
   output logic [3:0] o_pin_a,
   output logic [3:0] o_pin_b
);
   // Tri-stated LED lines light nothing
   assign o_lit_c = i_led_oe ? ~i_led_c_n : 4'h0;
   assign o_lit_d = i_led_oe ? ~i_led_d_n : 4'h0;
   assign o_pin_a = (i_a_oe & i_a) | ~i_a_oe;
   assign o_pin_b = i_b_oe & i_b;
endmodule // plc_port_model

// File: plc_top_tb.sv
// Testbench for the port LED and output control block.
// Assumes the port model resolves pins; blink step shortened to 4 cycles.
`timescale 1ns/1ps
module plc_top_tb;
   typedef struct packed {
      plc_pkg::plc_out_scope_t sc;
      logic [1:0] p;
      plc_pkg::plc_out_cfg_t w;
      logic [15:0] e;
   } plc_row_t;
   logic clk, rst_n, proto, master, sync_i, chain_i, we;
   plc_pkg::plc_out_scope_t scope;
   logic [1:0] port;
   plc_pkg::plc_out_cfg_t wdata;
   plc_pkg::plc_led_cfg_t [7:0] cfg;
   logic spi, led_oe, sync_o, sync_oe, chain_o;
   logic [3:0] c_n, d_n, oa, oa_oe, ob, ob_oe, lit_c, lit_d, pin_a, pin_b;
   int num_errors = 0, total_checks = 0, n;
   plc_row_t rows [5];
   int lvl [3] = '{0, 64, 255};
   plc_top #(.PORTS(4), .STEP_CYCLES(4)) i_dut (.i_clock(clk), .i_rst_n(rst_n),
      .i_proto_sel(proto), .i_tb_master(master), .i_led_cfg(cfg),
      .i_blink_sync_pin_i(sync_i), .i_blink_chain_in(chain_i), .i_out_we(we),
      .i_out_scope(scope), .i_out_port(port), .i_out_wdata(wdata), .o_proto_spi(spi),
      .o_led_c_n(c_n), .o_led_d_n(d_n), .o_led_oe(led_oe), .o_blink_sync_pin_o(sync_o),
      .o_blink_sync_pin_oe(sync_oe), .o_blink_chain_out(chain_o), .o_out_a(oa),
      .o_out_a_oe(oa_oe), .o_out_b(ob), .o_out_b_oe(ob_oe));
   plc_port_model i_model (.i_led_c_n(c_n), .i_led_d_n(d_n), .i_led_oe(led_oe),
      .i_a(oa), .i_a_oe(oa_oe), .i_b(ob), .i_b_oe(ob_oe), .o_lit_c(lit_c),
      .o_lit_d(lit_d), .o_pin_a(pin_a), .o_pin_b(pin_b));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input logic s);
      @(posedge clk);
      rst_n <= 1'b0;
      proto <= s;
      cyc(10);
      check({led_oe, oa_oe, ob_oe, oa, ob, pin_a, pin_b}, 32'h0000f0f0);
      @(posedge clk);
      rst_n <= 1'b1;
      cyc(2);
      check({spi, led_oe, lit_c, lit_d}, {s, 1'b1, 8'h00});
   endtask
   // Count lit cycles of LED C on port 1 over a window
   task automatic count_lit(input int k);
      n = 0;
      repeat (k) begin
         cyc(1);
         n += lit_c[1];
      end
   endtask
   initial begin
      #2000000;
      num_errors++;
      complete_run();
   end
   initial begin
      rst_n = 1'b0; proto = 1'b0; master = 1'b1; sync_i = 1'b0; chain_i = 1'b0;
      we = 1'b0; scope = plc_pkg::PLC_OW_PORT; port = 2'h0; wdata = '0;
      for (int i = 0; i < 8; i++) cfg[i] = {plc_pkg::PLC_LED_OFF, 8'h00, 8'h01, 8'h02};
      // Values written before enables
      rows[0] = '{plc_pkg::PLC_OW_PORT, 2'h1, 4'h1, 16'hd020};
      rows[1] = '{plc_pkg::PLC_OW_DEVICE, 2'h0, 4'h1, 16'h00f0};
      rows[2] = '{plc_pkg::PLC_OW_DEVICE, 2'h0, 4'hd, 16'h0fff};
      rows[3] = '{plc_pkg::PLC_OW_PORT, 2'h3, 4'h6, 16'h877f};
      rows[4] = '{plc_pkg::PLC_OW_BCAST, 2'h2, 4'h2, 16'hf000};
      do_reset(1'b0);
      foreach (rows[i]) begin
         @(posedge clk);
         we <= 1'b1;
         scope <= rows[i].sc;
         port <= rows[i].p;
         wdata <= rows[i].w;
         @(posedge clk);
         we <= 1'b0;
         #1;
         check({oa, oa_oe, ob, ob_oe}, rows[i].e);
      end
      $display("test outputs done");
      cfg[3].mode <= plc_pkg::PLC_LED_ON;
      cyc(3);
      check({lit_d, c_n}, 16'h002f);
      foreach (lvl[i]) begin
         cfg[2] <= {plc_pkg::PLC_LED_PWM, 8'(lvl[i]), 8'h01, 8'h01};
         cyc(3);
         count_lit(256);
         check(16'(n), 16'(lvl[i]));
      end
      cfg[2].mode <= plc_pkg::PLC_LED_BLINK;
      cfg[2].intensity <= 8'hff;
      cyc(20);
      count_lit(240);
      check(16'(n >= 76 && n <= 84), 16'h0001);
      $display("test leds done");
      count_lit(40);
      n = 0;
      repeat (40) begin
         n += chain_o;
         cyc(1);
      end
      check(16'(n > 0 && n < 40), 16'h0001);
      master <= 1'b0;
      chain_i <= 1'b1;
      cyc(3);
      check(16'(chain_o), 16'h0001);
      chain_i <= 1'b0;
      cyc(3);
      check(16'(chain_o), 16'h0000);
      // LED settings survive reset; clear them so the release check sees dark lines
      for (int i = 0; i < 8; i++) cfg[i] <= {plc_pkg::PLC_LED_OFF, 8'h00, 8'h01, 8'h02};
      do_reset(1'b1);
      master <= 1'b1;
      cyc(20);
      check({sync_oe, chain_o}, 2'h3);
      n = 0;
      repeat (40) begin
         n += sync_o;
         cyc(1);
      end
      check(16'(n > 0 && n < 40), 16'h0001);
      master <= 1'b0;
      cyc(2);
      check(16'(sync_oe), 16'h0000);
      $display("test timebase done");
      complete_run();
   end
endmodule // plc_top_tb
